//--- logic/dci_pkg.sv
// constants and types shared by the dsp core interrupt controller
package dci_pkg;
  // register bus geometry
  localparam int unsigned DCI_AW = 4;
  localparam int unsigned DCI_DW = 16;
  localparam int unsigned DCI_VW = 24;
  localparam int unsigned DCI_NPER = 15;
  localparam int unsigned DCI_NLVL = 16;
  localparam int unsigned DCI_NFLAG = 2;
  localparam int unsigned DCI_NEV = 4;
  // register offsets
  localparam logic [3:0] DCI_A_CTRL = 4'h0;
  localparam logic [3:0] DCI_A_MASK = 4'h1;
  localparam logic [3:0] DCI_A_LATCH = 4'h2;
  localparam logic [3:0] DCI_A_PRIO0 = 4'h3;
  localparam logic [3:0] DCI_A_IRQ_STS = 4'h7;
  localparam logic [3:0] DCI_A_IRQ_MSK = 4'h8;
  localparam logic [3:0] DCI_A_FLAG_CFG = 4'h9;
  localparam logic [3:0] DCI_A_STACK = 4'hA;
  localparam logic [3:0] DCI_A_ACTIVE = 4'hB;
  // control register fields
  localparam int unsigned DCI_C_NEST = 4;
  localparam int unsigned DCI_C_GIE = 5;
  localparam int unsigned DCI_C_BIAS = 7;
  localparam int unsigned DCI_C_PCSTK = 10;
  localparam int unsigned DCI_C_LPSTK = 11;
  localparam logic [15:0] DCI_CTRL_WMASK = 16'h0CB0;
  // reset values
  localparam logic [15:0] DCI_CTRL_RST = 16'h0000;
  localparam logic [15:0] DCI_MASK_RST = 16'h0000;
  localparam logic [15:0] DCI_LATCH_RST = 16'h0000;
  localparam logic [15:0] DCI_PRIO_RST [4] = '{16'h3210, 16'h7654, 16'hBA98, 16'h0BBB};
  localparam logic [3:0] DCI_FLAG_CFG_RST = 4'h0;
  // fixed mask/latch positions and priority mapping
  localparam int unsigned DCI_L_RESET = 0;
  localparam int unsigned DCI_L_PWRDN = 1;
  localparam int unsigned DCI_L_STACK = 2;
  localparam int unsigned DCI_L_KERNEL = 3;
  localparam logic [3:0] DCI_L_USER0 = 4'h4;
  localparam logic [3:0] DCI_L_LAST = 4'hF;
  localparam logic [3:0] DCI_PRIO_CAP = 4'hB;
  localparam logic [15:0] DCI_NOMASK = 16'h0003;
  // vectors
  localparam logic [23:0] DCI_VEC_STEP = 24'h00_0020;
  localparam logic [23:0] DCI_VEC_NOBOOT = 24'h01_0000;
  // stacks
  localparam int unsigned DCI_PC_DEPTH = 33;
  localparam int unsigned DCI_LOOP_DEPTH = 8;
  localparam int unsigned DCI_STAT_DEPTH = 16;
  localparam logic [5:0] DCI_PC_LOW = 6'h03;
  localparam logic [5:0] DCI_PC_HIGH = 6'h1C;
  // interrupt event bits
  localparam int unsigned DCI_E_TAKEN = 0;
  localparam int unsigned DCI_E_STKLVL = 1;
  localparam int unsigned DCI_E_STKERR = 2;
  localparam int unsigned DCI_E_EMU = 3;
  // flag pin trigger modes
  localparam logic [1:0] DCI_FM_LEVEL = 2'h0;
  localparam logic [1:0] DCI_FM_RISE = 2'h1;
  localparam logic [1:0] DCI_FM_FALL = 2'h2;
  localparam logic [1:0] DCI_FM_BOTH = 2'h3;
  typedef enum logic [0:0] {
    DCI_IDLE = 1'b0,
    DCI_OFFER = 1'b1
  } dci_state_t;
endpackage

//--- logic/dci_intc.sv
// prioritised interrupt controller with nesting stacks for a dsp core
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module dci_intc
  import dci_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // register port
  input wire logic [DCI_AW-1:0] reg_addr_in,
  input wire logic [DCI_DW-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DCI_DW-1:0] reg_rdata_out,
  // interrupt sources
  input wire logic emu_req_in,
  input wire logic reset_req_in,
  input wire logic pwrdn_req_in,
  input wire logic kernel_req_in,
  input wire logic [DCI_NPER-1:0] periph_req_in,
  input wire logic [DCI_NFLAG-1:0] flag_pin_in,
  // program sequencer
  input wire logic no_boot_in,
  input wire logic global_irq_on_instr_in,
  input wire logic global_irq_off_instr_in,
  output logic vector_valid_out,
  output logic [DCI_VW-1:0] vector_addr_out,
  output logic [3:0] vector_level_out,
  input wire logic vector_ack_in,
  input wire logic [DCI_VW-1:0] return_addr_in,
  input wire logic [DCI_DW-1:0] status_in,
  input wire logic rti_in,
  output logic emu_irq_out,
  output logic biased_round_out,
  // pc and loop stacks for calls and loops
  input wire logic pc_push_in,
  input wire logic pc_pop_in,
  input wire logic [DCI_VW-1:0] pc_push_data_in,
  output logic [DCI_VW-1:0] pc_pop_data_out,
  output logic [DCI_DW-1:0] status_pop_data_out,
  input wire logic loop_push_in,
  input wire logic loop_pop_in,
  input wire logic [DCI_VW-1:0] loop_push_data_in,
  output logic [DCI_VW-1:0] loop_pop_data_out,
  // summary interrupt
  output logic irq_out
);

  // lowest set bit index, bit 4 set when none
  function automatic logic [4:0] first_set(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // priority level to mask/latch position
  function automatic logic [3:0] level_pos(input logic [3:0] prio);
    logic [3:0] p;
    if (prio >= DCI_PRIO_CAP) begin
      p = DCI_L_LAST;
    end else begin
      p = prio + DCI_L_USER0;
    end
    return p;
  endfunction

  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic [15:0] mask_r;
  logic [15:0] latch_r;
  logic [15:0] prio_r [4];
  logic [3:0] flag_cfg_r;
  logic [DCI_NFLAG-1:0] flag_prev_r;
  logic [DCI_NEV-1:0] irq_sts_r;
  logic [DCI_NEV-1:0] irq_msk_r;
  logic [15:0] active_r;
  dci_state_t st_r;
  logic [3:0] vec_idx_r;
  logic [5:0] pc_cnt_r;
  logic [4:0] stat_cnt_r;
  logic [3:0] loop_cnt_r;
  logic [DCI_VW-1:0] pc_mem [DCI_PC_DEPTH];
  logic [DCI_DW-1:0] stat_mem [DCI_STAT_DEPTH];
  logic [DCI_VW-1:0] loop_mem [DCI_LOOP_DEPTH];

  logic wr_ctrl;
  logic wr_mask;
  logic wr_latch;
  logic wr_sts;
  logic [15:0] src_hot [DCI_NPER];
  logic [DCI_NFLAG-1:0] flag_hit;
  logic [15:0] periph_set;
  logic [15:0] hw_set;
  logic [15:0] ack_clr;
  logic [15:0] pending;
  logic [4:0] cand;
  logic [4:0] act_top;
  logic stack_lvl;
  logic grant;
  logic take;
  logic pc_push;
  logic pc_pop;
  logic [DCI_VW-1:0] pc_wdata;
  logic pc_err;
  logic stat_err;
  logic loop_err;
  logic [DCI_NEV-1:0] ev;

  assign wr_ctrl = reg_wr_in && (reg_addr_in == DCI_A_CTRL);
  assign wr_mask = reg_wr_in && (reg_addr_in == DCI_A_MASK);
  assign wr_latch = reg_wr_in && (reg_addr_in == DCI_A_LATCH);
  assign wr_sts = reg_wr_in && (reg_addr_in == DCI_A_IRQ_STS);

  // flag pin triggers and peripheral level mapping
  genvar g;
  generate
    for (g = 0; g < DCI_NFLAG; g++) begin : g_flag
      logic rise;
      logic fall;
      assign rise = flag_pin_in[g] && !flag_prev_r[g];
      assign fall = !flag_pin_in[g] && flag_prev_r[g];
      always_comb begin
        unique case (flag_cfg_r[2*g +: 2])
          DCI_FM_LEVEL: flag_hit[g] = flag_pin_in[g];
          DCI_FM_RISE: flag_hit[g] = rise;
          DCI_FM_FALL: flag_hit[g] = fall;
          DCI_FM_BOTH: flag_hit[g] = rise || fall;
        endcase
      end
    end
    for (g = 0; g < DCI_NPER; g++) begin : g_src
      logic req;
      logic [3:0] prio;
      assign prio = prio_r[g / 4][4*(g % 4) +: 4];
      if (g == 12 || g == 13) begin : g_fl
        assign req = periph_req_in[g] || flag_hit[g - 12];
      end else begin : g_pl
        assign req = periph_req_in[g];
      end
      assign src_hot[g] = req ? (16'h0001 << level_pos(prio)) : 16'h0000;
    end
  endgenerate

  always_comb begin
    periph_set = 16'h0000;
    for (int i = 0; i < DCI_NPER; i++) begin
      periph_set = periph_set | src_hot[i];
    end
  end

  // stack level interrupt, enabled separately for the pc and loop stacks
  assign stack_lvl = (ctrl_r[DCI_C_PCSTK] && (pc_cnt_r < DCI_PC_LOW || pc_cnt_r > DCI_PC_HIGH))
                  || (ctrl_r[DCI_C_LPSTK] && loop_cnt_r == 4'(DCI_LOOP_DEPTH));

  always_comb begin
    hw_set = periph_set;
    hw_set[DCI_L_RESET] = reset_req_in;
    hw_set[DCI_L_PWRDN] = pwrdn_req_in;
    hw_set[DCI_L_STACK] = stack_lvl;
    hw_set[DCI_L_KERNEL] = kernel_req_in;
  end

  // and with mask, lowest index wins
  assign pending = latch_r & (mask_r | DCI_NOMASK);
  assign cand = first_set(pending);
  assign act_top = first_set(active_r);

  always_comb begin
    grant = 1'b0;
    if (!cand[4] && !emu_req_in && st_r == DCI_IDLE) begin
      if (cand[3:0] == 4'(DCI_L_RESET)) begin
        grant = 1'b1;
      end else if (ctrl_r[DCI_C_GIE]) begin
        grant = act_top[4] || (ctrl_r[DCI_C_NEST] && cand < act_top);
      end
    end
  end

  assign take = (st_r == DCI_OFFER) && vector_ack_in;
  assign ack_clr = take ? (16'h0001 << vec_idx_r) : 16'h0000;

  // control register and global enable instructions
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = reg_wdata_in & DCI_CTRL_WMASK;
    end
    if (global_irq_on_instr_in) begin
      ctrl_nxt[DCI_C_GIE] = 1'b1;
    end
    if (global_irq_off_instr_in) begin
      ctrl_nxt[DCI_C_GIE] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ctrl_r <= DCI_CTRL_RST;
    end else if (ce_in) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      mask_r <= DCI_MASK_RST;
      flag_cfg_r <= DCI_FLAG_CFG_RST;
      irq_msk_r <= '0;
    end else if (ce_in && reg_wr_in) begin
      if (wr_mask) begin
        mask_r <= reg_wdata_in;
      end
      if (reg_addr_in == DCI_A_FLAG_CFG) begin
        flag_cfg_r <= reg_wdata_in[3:0];
      end
      if (reg_addr_in == DCI_A_IRQ_MSK) begin
        irq_msk_r <= reg_wdata_in[DCI_NEV-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < 4; i++) begin
        prio_r[i] <= DCI_PRIO_RST[i];
      end
    end else if (ce_in && reg_wr_in) begin
      for (int i = 0; i < 4; i++) begin
        if (reg_addr_in == DCI_A_PRIO0 + 4'(i)) begin
          prio_r[i] <= reg_wdata_in;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      latch_r <= DCI_LATCH_RST;
    end else if (ce_in) begin
      latch_r <= ((wr_latch ? reg_wdata_in : latch_r) & ~ack_clr) | hw_set;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      flag_prev_r <= '0;
    end else if (ce_in) begin
      flag_prev_r <= flag_pin_in;
    end
  end

  // vector offer and acknowledge
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      st_r <= DCI_IDLE;
      vec_idx_r <= 4'h0;
      vector_addr_out <= '0;
    end else if (ce_in) begin
      unique case (st_r)
        DCI_IDLE: begin
          if (grant) begin
            st_r <= DCI_OFFER;
            vec_idx_r <= cand[3:0];
            vector_addr_out <= (no_boot_in ? DCI_VEC_NOBOOT : 24'h00_0000)
                             + 24'(24'(cand[3:0]) * DCI_VEC_STEP);
          end
        end
        DCI_OFFER: begin
          if (vector_ack_in) begin
            st_r <= DCI_IDLE;
          end
        end
      endcase
    end
  end

  assign vector_valid_out = (st_r == DCI_OFFER);
  assign vector_level_out = vec_idx_r;

  // in-service levels for nesting
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      active_r <= '0;
    end else if (ce_in) begin
      active_r <= (active_r & ~((rti_in && !act_top[4]) ? (16'h0001 << act_top[3:0]) : 16'h0000))
                | ack_clr;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      emu_irq_out <= 1'b0;
    end else if (ce_in) begin
      emu_irq_out <= emu_req_in;
    end
  end

  assign biased_round_out = ctrl_r[DCI_C_BIAS];

  // push on entry, pop on return
  assign pc_push = take || pc_push_in;
  assign pc_pop = rti_in || pc_pop_in;
  assign pc_wdata = take ? return_addr_in : pc_push_data_in;
  assign pc_err = (pc_push && pc_cnt_r == 6'(DCI_PC_DEPTH)) || (pc_pop && pc_cnt_r == 6'h00);
  assign stat_err = (take && stat_cnt_r == 5'(DCI_STAT_DEPTH)) || (rti_in && stat_cnt_r == 5'h00);
  assign loop_err = (loop_push_in && loop_cnt_r == 4'(DCI_LOOP_DEPTH))
                 || (loop_pop_in && loop_cnt_r == 4'h0);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pc_cnt_r <= '0;
      stat_cnt_r <= '0;
      loop_cnt_r <= '0;
    end else if (ce_in) begin
      if (!pc_err && pc_push) begin
        pc_cnt_r <= pc_cnt_r + 6'h01;
      end else if (!pc_err && pc_pop) begin
        pc_cnt_r <= pc_cnt_r - 6'h01;
      end
      if (!stat_err && take) begin
        stat_cnt_r <= stat_cnt_r + 5'h01;
      end else if (!stat_err && rti_in) begin
        stat_cnt_r <= stat_cnt_r - 5'h01;
      end
      if (!loop_err && loop_push_in) begin
        loop_cnt_r <= loop_cnt_r + 4'h1;
      end else if (!loop_err && loop_pop_in) begin
        loop_cnt_r <= loop_cnt_r - 4'h1;
      end
    end
  end

  // stack storage and popped values
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pc_pop_data_out <= '0;
      status_pop_data_out <= '0;
      loop_pop_data_out <= '0;
    end else if (ce_in) begin
      if (!pc_err && pc_push) begin
        pc_mem[pc_cnt_r] <= pc_wdata;
      end else if (!pc_err && pc_pop) begin
        pc_pop_data_out <= pc_mem[pc_cnt_r - 6'h01];
      end
      if (!stat_err && take) begin
        stat_mem[stat_cnt_r[3:0]] <= status_in;
      end else if (!stat_err && rti_in) begin
        status_pop_data_out <= stat_mem[4'(stat_cnt_r - 5'h01)];
      end
      if (!loop_err && loop_push_in) begin
        loop_mem[loop_cnt_r[2:0]] <= loop_push_data_in;
      end else if (!loop_err && loop_pop_in) begin
        loop_pop_data_out <= loop_mem[3'(loop_cnt_r - 4'h1)];
      end
    end
  end

  // sticky events, write one to clear, set wins
  always_comb begin
    ev = '0;
    ev[DCI_E_TAKEN] = take;
    ev[DCI_E_STKLVL] = stack_lvl;
    ev[DCI_E_STKERR] = pc_err || stat_err || loop_err;
    ev[DCI_E_EMU] = emu_req_in;
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      irq_sts_r <= '0;
    end else if (ce_in) begin
      irq_sts_r <= (irq_sts_r & ~(wr_sts ? reg_wdata_in[DCI_NEV-1:0] : '0)) | ev;
    end
  end

  assign irq_out = |(irq_sts_r & irq_msk_r);

  // read data, one cycle after the strobe
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= '0;
    end else if (ce_in) begin
      reg_rdata_out <= '0;
      if (reg_rd_in) begin
        unique case (reg_addr_in)
          DCI_A_CTRL: reg_rdata_out <= ctrl_r;
          DCI_A_MASK: reg_rdata_out <= mask_r;
          DCI_A_LATCH: reg_rdata_out <= latch_r;
          4'h3: reg_rdata_out <= prio_r[0];
          4'h4: reg_rdata_out <= prio_r[1];
          4'h5: reg_rdata_out <= prio_r[2];
          4'h6: reg_rdata_out <= prio_r[3];
          DCI_A_IRQ_STS: reg_rdata_out <= {12'h000, irq_sts_r};
          DCI_A_IRQ_MSK: reg_rdata_out <= {12'h000, irq_msk_r};
          DCI_A_FLAG_CFG: reg_rdata_out <= {12'h000, flag_cfg_r};
          DCI_A_STACK: reg_rdata_out <= {4'h0, loop_cnt_r, 2'b00, pc_cnt_r};
          DCI_A_ACTIVE: reg_rdata_out <= active_r;
          default: reg_rdata_out <= '0;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

//--- tb/dci_intc_monitor.sv
// port checker for the interrupt controller
`timescale 1ns/1ns
`default_nettype none
module dci_intc_monitor
  import dci_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // register port
  input wire logic [DCI_AW-1:0] reg_addr_in,
  input wire logic [DCI_DW-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [DCI_DW-1:0] reg_rdata_out,
  // requests and vectors
  input wire logic emu_req_in,
  input wire logic reset_req_in,
  input wire logic no_boot_in,
  input wire logic vector_ack_in,
  input wire logic vector_valid_out,
  input wire logic [DCI_VW-1:0] vector_addr_out,
  input wire logic [3:0] vector_level_out,
  input wire logic emu_irq_out,
  input wire logic biased_round_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);
  a_reset_first:
    assert property ($rose(vector_valid_out) && $past(reset_req_in, 2)
      |-> vector_level_out == 4'h0) else $error("reset request not first");
  a_vector_step:
    assert property (vector_valid_out |-> vector_addr_out[23:17] == 7'h00
      && vector_addr_out[15:0] == {7'h00, vector_level_out, 5'h00}) else $error("bad vector");
  a_noboot_offset:
    assert property ($rose(vector_valid_out) |-> vector_addr_out[16] == $past(no_boot_in))
      else $error("bad no-boot offset");
  a_offer_holds:
    assert property (vector_valid_out && !vector_ack_in |=> vector_valid_out
      && $stable(vector_addr_out) && $stable(vector_level_out)) else $error("offer changed");
  a_ack_drops:
    assert property (vector_valid_out && vector_ack_in |=> !vector_valid_out)
      else $error("offer stayed after ack");
  a_emu_blocks:
    assert property (emu_req_in && !vector_valid_out |=> !vector_valid_out)
      else $error("offer during emulator request");
  a_emu_copy:
    assert property (!$past(reset_in) |-> emu_irq_out == $past(emu_req_in))
      else $error("emulator output wrong");
  a_bias_write:
    assert property (reg_wr_in && reg_addr_in == DCI_A_CTRL
      |=> biased_round_out == $past(reg_wdata_in[DCI_C_BIAS])) else $error("bias bit wrong");
  a_ctrl_reserved:
    assert property (reg_rd_in && reg_addr_in == DCI_A_CTRL
      |=> (reg_rdata_out & ~DCI_CTRL_WMASK) == 16'h0000) else $error("reserved bit set");
endmodule
bind dci_intc dci_intc_monitor mon (
  .ref_clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
  .reg_rdata_out, .emu_req_in, .reset_req_in, .no_boot_in, .vector_ack_in,
  .vector_valid_out, .vector_addr_out, .vector_level_out, .emu_irq_out, .biased_round_out
);
`default_nettype wire

//--- tb/dci_seq_model.sv
// sequencer stand-in that takes offered vectors after a set wait
`timescale 1ns/1ns
`default_nettype none
module dci_seq_model
  import dci_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // vector handshake
  input wire logic vector_valid_in,
  input wire logic [3:0] wait_in,
  output logic vector_ack_out,
  output logic [DCI_VW-1:0] return_addr_out,
  output logic [DCI_DW-1:0] status_out
);
  logic [3:0] cnt_r;
  logic [DCI_VW-1:0] stamp_r;
  // one-cycle ack pulse after the wait, count cleared while not offered
  always_ff @(posedge ref_clk_in) begin
    if (reset_in || !vector_valid_in || vector_ack_out) begin
      cnt_r <= 4'h0;
      vector_ack_out <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      vector_ack_out <= (cnt_r == wait_in);
    end
  end
  // context words change every cycle
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      stamp_r <= 24'h00_0000;
    end else begin
      stamp_r <= stamp_r + 24'h00_0001;
    end
  end
  assign return_addr_out = stamp_r;
  assign status_out = ~stamp_r[15:0];
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import dci_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, emu = 1'b0, rreq = 1'b0;
  logic pd = 1'b0, kr = 1'b0, nb = 1'b0, on = 1'b0, off = 1'b0, rti = 1'b0;
  logic psh = 1'b0, pop = 1'b0, lpsh = 1'b0, lpop = 1'b0, ce = 1'b1;
  logic [3:0] addr = 4'h0, wt = 4'h0;
  logic [15:0] wd = 16'h0000;
  logic [14:0] prq = 15'h0000;
  logic [1:0] pin = 2'h0;
  logic vv, ack, irq, eirq;
  logic [23:0] va, ra, ppd, lpd;
  logic [23:0] ra_cap = 24'h00_0000;
  logic [15:0] rdata, st, spd;
  int mismatches = 0;
  int n_tests = 0;
  always #25 clk = ~clk;
  dci_intc dut (.ref_clk_in(clk), .reset_in(rst), .ce_in(ce), .reg_addr_in(addr),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .emu_req_in(emu), .reset_req_in(rreq), .pwrdn_req_in(pd), .kernel_req_in(kr),
    .periph_req_in(prq), .flag_pin_in(pin), .no_boot_in(nb), .global_irq_on_instr_in(on),
    .global_irq_off_instr_in(off), .vector_valid_out(vv), .vector_addr_out(va),
    .vector_level_out(), .vector_ack_in(ack), .return_addr_in(ra), .status_in(st),
    .rti_in(rti), .emu_irq_out(eirq), .biased_round_out(), .pc_push_in(psh),
    .pc_pop_in(pop), .pc_push_data_in(24'h00_0123), .pc_pop_data_out(ppd),
    .status_pop_data_out(spd), .loop_push_in(lpsh), .loop_pop_in(lpop),
    .loop_push_data_in(24'h00_0456), .loop_pop_data_out(lpd), .irq_out(irq));
  dci_seq_model seq (.ref_clk_in(clk), .reset_in(rst), .vector_valid_in(vv),
    .wait_in(wt), .vector_ack_out(ack), .return_addr_out(ra), .status_out(st));
  task automatic report_and_stop();
    if (mismatches == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, e});
  endtask
  task automatic req(input logic [14:0] p, input logic [2:0] s);
    @(posedge clk);
    prq <= p;
    {kr, pd, rreq} <= s;
    @(posedge clk);
    prq <= 15'h0000;
    {kr, pd, rreq} <= 3'h0;
  endtask
  task automatic ins(input logic o);
    @(posedge clk);
    on <= o;
    off <= ~o;
    @(posedge clk);
    on <= 1'b0;
    off <= 1'b0;
  endtask
  task automatic ret();
    @(posedge clk);
    rti <= 1'b1;
    @(posedge clk);
    rti <= 1'b0;
  endtask
  task automatic stk(input logic [3:0] s, input int n);
    repeat (n) begin
      @(posedge clk);
      {lpop, lpsh, pop, psh} <= s;
      @(posedge clk);
      {lpop, lpsh, pop, psh} <= 4'h0;
    end
  endtask
  // e: offer expected at address a; r: return from handler afterwards
  task automatic vec(input logic e, input logic [23:0] a, input logic r);
    int i;
    i = 0;
    while (i < 12 && vv !== 1'b1) begin
      @(posedge clk);
      #1 i++;
    end
    chk({23'h0, vv}, {23'h0, e});
    if (e && vv !== 1'b1) report_and_stop();
    if (vv === 1'b1) chk(va, a);
    i = 0;
    while (i < 30 && vv === 1'b1) begin
      if (ack === 1'b1) ra_cap = ra;
      @(posedge clk);
      #1 i++;
    end
    if (i == 30) begin
      mismatches++;
      report_and_stop();
    end
    if (r && e) ret();
  endtask
  task automatic t_reset();
    rreg(DCI_A_CTRL, 16'h0000);
    rreg(DCI_A_MASK, 16'h0000);
    rreg(DCI_A_LATCH, 16'h0000);
    rreg(DCI_A_PRIO0, 16'h3210);
    rreg(4'h4, 16'h7654);
    rreg(4'h5, 16'hBA98);
    rreg(4'h6, 16'h0BBB);
    rreg(4'hF, 16'h0000);
    wreg(DCI_A_CTRL, 16'hFFFF);
    rreg(DCI_A_CTRL, 16'h0CB0);
    wreg(DCI_A_CTRL, 16'h0000);
    wreg(DCI_A_LATCH, 16'h0000);
  endtask
  task automatic t_prio();
    logic [3:0] l;
    ins(1'b1);
    wreg(DCI_A_MASK, 16'hFFF0);
    for (int k = 0; k < 12; k++) begin
      l = 4'(k);
      wreg(DCI_A_PRIO0, {12'h321, l});
      req(15'h0001, 3'h0);
      vec(1'b1, {15'h0000, l + 4'h4, 5'h00}, 1'b1);
    end
    nb <= 1'b1;
    req(15'h0002, 3'h0);
    vec(1'b1, 24'h01_00A0, 1'b1);
    nb <= 1'b0;
    wreg(DCI_A_MASK, 16'hFFD0);
    req(15'h0002, 3'h0);
    vec(1'b0, 24'h00_0000, 1'b0);
    rreg(DCI_A_LATCH, 16'h0020);
    wreg(DCI_A_LATCH, 16'h0000);
    rreg(DCI_A_LATCH, 16'h0000);
    wreg(DCI_A_LATCH, 16'h0040);
    vec(1'b1, 24'h00_00C0, 1'b1);
    rreg(DCI_A_LATCH, 16'h0000);
    wreg(DCI_A_PRIO0, 16'h3210);
  endtask
  task automatic t_nmi();
    ins(1'b0);
    wreg(DCI_A_MASK, 16'h0000);
    req(15'h0000, 3'h1);
    vec(1'b1, 24'h00_0000, 1'b1);
    req(15'h0000, 3'h2);
    vec(1'b0, 24'h00_0000, 1'b0);
    ins(1'b1);
    vec(1'b1, 24'h00_0020, 1'b1);
    wreg(DCI_A_MASK, 16'h0008);
    emu <= 1'b1;
    req(15'h0000, 3'h4);
    vec(1'b0, 24'h00_0000, 1'b0);
    chk({23'h0, eirq}, 24'h00_0001);
    @(posedge clk);
    emu <= 1'b0;
    vec(1'b1, 24'h00_0060, 1'b1);
  endtask
  task automatic t_nest();
    wreg(DCI_A_MASK, 16'hFFF0);
    wt <= 4'h3;
    req(15'h0002, 3'h0);
    vec(1'b1, 24'h00_00A0, 1'b0);
    rreg(DCI_A_STACK, 16'h0001);
    req(15'h0001, 3'h0);
    vec(1'b0, 24'h00_0000, 1'b0);
    ret();
    vec(1'b1, 24'h00_0080, 1'b1);
    rreg(DCI_A_STACK, 16'h0000);
    wreg(DCI_A_CTRL, 16'h0030);
    req(15'h0002, 3'h0);
    vec(1'b1, 24'h00_00A0, 1'b0);
    req(15'h0001, 3'h0);
    vec(1'b1, 24'h00_0080, 1'b1);
    #1 chk(ppd, ra_cap);
    chk({8'h00, spd}, {8'h00, ~ra_cap[15:0]});
    ret();
    rreg(DCI_A_STACK, 16'h0000);
    wt <= 4'h0;
  endtask
  task automatic t_irq();
    wreg(DCI_A_IRQ_MSK, 16'h0001);
    #1 chk({23'h0, irq}, 24'h00_0001);
    wreg(DCI_A_IRQ_STS, 16'h000F);
    #1 chk({23'h0, irq}, 24'h00_0000);
    wreg(DCI_A_LATCH, 16'h0040);
    vec(1'b1, 24'h00_00C0, 1'b1);
    chk({23'h0, irq}, 24'h00_0001);
    wreg(DCI_A_IRQ_MSK, 16'h0000);
    #1 chk({23'h0, irq}, 24'h00_0000);
    wreg(DCI_A_IRQ_STS, 16'h000F);
  endtask
  task automatic t_stack();
    stk(4'h1, 3);
    wreg(DCI_A_CTRL, 16'h0420);
    rreg(DCI_A_LATCH, 16'h0000);
    stk(4'h2, 1);
    #1 chk(ppd, 24'h00_0123);
    rreg(DCI_A_LATCH, 16'h0004);
    stk(4'h1, 26);
    wreg(DCI_A_LATCH, 16'h0000);
    rreg(DCI_A_LATCH, 16'h0000);
    stk(4'h1, 1);
    rreg(DCI_A_LATCH, 16'h0004);
    stk(4'h1, 5);
    rreg(DCI_A_STACK, 16'h0021);
    stk(4'h2, 33);
    wreg(DCI_A_CTRL, 16'h0820);
    stk(4'h4, 7);
    wreg(DCI_A_LATCH, 16'h0000);
    rreg(DCI_A_LATCH, 16'h0000);
    stk(4'h4, 2);
    rreg(DCI_A_LATCH, 16'h0004);
    rreg(DCI_A_STACK, 16'h0800);
    stk(4'h8, 8);
    #1 chk(lpd, 24'h00_0456);
    wreg(DCI_A_CTRL, 16'h0020);
    wreg(DCI_A_LATCH, 16'h0000);
  endtask
  task automatic t_flag();
    wreg(DCI_A_MASK, 16'h8000);
    for (int m = 0; m < 4; m++) begin
      wreg(DCI_A_FLAG_CFG, 16'(m));
      @(posedge clk);
      pin <= 2'h1;
      @(posedge clk);
      if (m == 0) pin <= 2'h0;
      vec(m != 2, 24'h00_01E0, 1'b1);
      @(posedge clk);
      pin <= 2'h0;
      vec(m > 1, 24'h00_01E0, 1'b1);
    end
  endtask
  // clock enable low freezes register writes
  task automatic t_ce();
    ce <= 1'b0;
    wreg(DCI_A_MASK, 16'h1234);
    ce <= 1'b1;
    rreg(DCI_A_MASK, 16'h8000);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_prio();
    t_nmi();
    t_nest();
    t_irq();
    t_stack();
    t_flag();
    t_ce();
    report_and_stop();
  end
endmodule
`default_nettype wire
